// ===== design/ccpo_pkg.sv
// shared constants, types and decode functions for the charger option control block
package ccpo_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_OPT_ONE   = 8'h30;
    localparam logic [7:0]  ADDR_OPT_TWO   = 8'h31;
    localparam logic [15:0] RESET_OPT_ONE  = 16'h0211;
    localparam logic [15:0] RESET_OPT_TWO  = 16'h02b7;

    // option word one field positions
    localparam int OPT1_DEGLITCH_LO   = 4;
    localparam int OPT1_LATCH_OFF     = 3;
    localparam int OPT1_SHIP_DCHG     = 1;
    localparam int OPT1_AUTO_WAKE     = 0;

    // option word two field positions
    localparam int OPT2_OVLD_TIME_LO  = 14;
    localparam int OPT2_ON_CURRENT    = 13;
    localparam int OPT2_ON_DROOP      = 12;
    localparam int OPT2_OVLD_FLAG     = 11;
    localparam int OPT2_RELAX_FLAG    = 10;
    localparam int OPT2_CYCLE_TIME_LO = 8;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          MS_CYCLES      = CLK_HZ / 1000;
    localparam logic [7:0]  SHIP_MS        = 8'h8c;        // 140 ms
    localparam int          WAKE_LIMIT_MIN = 30;
    localparam logic [20:0] WAKE_LIMIT_MS  = 21'(WAKE_LIMIT_MIN * 60 * 1000);

    localparam logic [5:0]  OVLD_MS_0 = 6'h01;   // 1 ms
    localparam logic [5:0]  OVLD_MS_1 = 6'h02;   // 2 ms
    localparam logic [5:0]  OVLD_MS_2 = 6'h0a;   // 10 ms
    localparam logic [5:0]  OVLD_MS_3 = 6'h14;   // 20 ms
    localparam logic [5:0]  CYCLE_MS_0 = 6'h05;  // 5 ms
    localparam logic [5:0]  CYCLE_MS_1 = 6'h0a;  // 10 ms
    localparam logic [5:0]  CYCLE_MS_2 = 6'h14;  // 20 ms
    localparam logic [5:0]  CYCLE_MS_3 = 6'h28;  // 40 ms

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ccpo_reg_req_t;

    typedef struct packed {
        logic comparator_trip;
        logic adapter_present;
        logic battery_below_min;
        logic input_overshoot;
        logic system_droop;
    } ccpo_sense_t;

    typedef enum logic [1:0] {
        SURGE_IDLE     = 2'b00,
        SURGE_OVERLOAD = 2'b01,
        SURGE_RELAX    = 2'b10
    } ccpo_surge_state_t;

    // overload duration in ms for a selector value
    function automatic logic [5:0] ccpo_ovld_ms(input logic [1:0] sel);
        case (sel)
            2'b00:   ccpo_ovld_ms = OVLD_MS_0;
            2'b01:   ccpo_ovld_ms = OVLD_MS_1;
            2'b10:   ccpo_ovld_ms = OVLD_MS_2;
            default: ccpo_ovld_ms = OVLD_MS_3;
        endcase
    endfunction

    // overload-plus-relax period in ms for a selector value
    function automatic logic [5:0] ccpo_cycle_ms(input logic [1:0] sel);
        case (sel)
            2'b00:   ccpo_cycle_ms = CYCLE_MS_0;
            2'b01:   ccpo_cycle_ms = CYCLE_MS_1;
            2'b10:   ccpo_cycle_ms = CYCLE_MS_2;
            default: ccpo_cycle_ms = CYCLE_MS_3;
        endcase
    endfunction

endpackage

// ===== design/ccpo_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module ccpo_pin_sync #(
    parameter int W = 5
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_sync_n,
    input  wire logic [W-1:0] pin_raw,
    output var  logic [W-1:0] pin_clean
);

    logic [W-1:0] stage_a;
    logic [W-1:0] stage_b;
    logic [W-1:0] stage_c;
    logic [W-1:0] next_pin_clean;

    // ----------------------------------------------------------------
    // agreement filter: stage_a is only read by stage_b
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                next_pin_clean[i] = (stage_b[i] == stage_c[i]) ? stage_c[i] : pin_clean[i];
            end
        end
    endgenerate

    // shift chain and filtered output
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stage_a   <= '0;
            stage_b   <= '0;
            stage_c   <= '0;
            pin_clean <= '0;
        end else begin
            stage_a   <= pin_raw;
            stage_b   <= stage_a;
            stage_c   <= stage_b;
            pin_clean <= next_pin_clean;
        end
    end

endmodule

`default_nettype wire

// ===== design/ccpo_option_ctrl.sv
// charger option registers, shipping and wakeup timers, peak power controller
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - latch-off set and comparator trips: disable converter, drive input-good low
// - ship discharge bit drives discharge, self-clears after 140 ms
// - auto-wakeup with battery below minimum: 128 mA charge, at most 30 minutes
// - battery rising above minimum during wakeup charge stops it, clears bit
// - overload time select 00/01/10/11 gives 1/2/10/20 ms
// - bit 13 enables peak power entry on input current overshoot
// - bit 12 enables peak power entry on system voltage droop
// - both trigger enables zero keeps peak power mode fully off
// - adapter removal clears both trigger enables to 00b
// - bit 11 reads overload phase; writing 0 leaves overload
// - bit 10 reads relax phase; writing 0 leaves relax
// - cycle time select 00/01/10/11 gives 5/10/20/40 ms
// - overload not shorter than cycle period means no relax phase
// - option word two resets to 2B7
// - deglitch select 00b disables comparator, no latch-off possible
module ccpo_option_ctrl
    import ccpo_pkg::*;
#(
    parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    input  wire ccpo_reg_req_t reg_req,
    output var  logic [15:0]   reg_rdata,
    output var  logic          reg_rvalid,
    input  wire ccpo_sense_t   sense_pins,
    output var  logic          converter_disable,
    output var  logic          input_good_indicator,
    output var  logic          ship_discharge_active,
    output var  logic          wake_charge_enable,
    output var  logic          surge_overload_active,
    output var  logic          surge_relax_active
);

    // ----------------------------------------------------------------
    // reset release and pin synchronisation
    // ----------------------------------------------------------------
    logic        rst_meta_n;
    logic        rst_sync_n;
    ccpo_sense_t sense;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    ccpo_pin_sync #(
        .W ($bits(ccpo_sense_t))
    ) u_pin_sync (
        .sys_clk    (sys_clk),
        .rst_sync_n (rst_sync_n),
        .pin_raw    (sense_pins),
        .pin_clean  (sense)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [13:0]       tick_cnt;
    logic [15:0]       opt_one;
    logic [15:0]       opt_two;        // bits 11:10 unused, flags come from the phase
    logic [7:0]        ship_ms;
    logic [20:0]       wake_ms;
    logic              latched;
    ccpo_surge_state_t surge_state;
    logic [5:0]        surge_ms;

    logic [13:0]       next_tick_cnt;
    logic [15:0]       next_opt_one;
    logic [15:0]       next_opt_two;
    logic [7:0]        next_ship_ms;
    logic [20:0]       next_wake_ms;
    logic              next_latched;
    ccpo_surge_state_t next_surge_state;
    logic [5:0]        next_surge_ms;
    logic [15:0]       next_reg_rdata;
    logic              next_wake_charge;

    logic              ms_tick;
    logic              wr_one;
    logic              wr_two;
    logic              trigger;
    logic [5:0]        ovld_len;
    logic [5:0]        cycle_len;
    logic [15:0]       opt_two_view;

    // ----------------------------------------------------------------
    // millisecond tick: one prescaler keeps every ms timer short
    // ----------------------------------------------------------------
    always_comb begin
        ms_tick       = (tick_cnt == 14'(MS_TICK_CYCLES - 1));
        next_tick_cnt = ms_tick ? 14'h0000 : tick_cnt + 14'h0001;
    end

    // ----------------------------------------------------------------
    // option registers, timers and peak power sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_opt_one     = opt_one;
        next_opt_two     = opt_two;
        next_ship_ms     = ship_ms;
        next_wake_ms     = wake_ms;
        next_surge_state = surge_state;
        next_surge_ms    = surge_ms;
        wr_one           = reg_req.wr && (reg_req.addr == ADDR_OPT_ONE);
        wr_two           = reg_req.wr && (reg_req.addr == ADDR_OPT_TWO);
        ovld_len  = ccpo_ovld_ms(opt_two[OPT2_OVLD_TIME_LO +: 2]);
        cycle_len = ccpo_cycle_ms(opt_two[OPT2_CYCLE_TIME_LO +: 2]);
        trigger   = (opt_two[OPT2_ON_CURRENT] && sense.input_overshoot)
                  || (opt_two[OPT2_ON_DROOP] && sense.system_droop);

        // latch-off holds until software drops the option bit
        next_latched = opt_one[OPT1_LATCH_OFF]
                     && (latched || (sense.comparator_trip
                         && (opt_one[OPT1_DEGLITCH_LO +: 2] != 2'b00)));

        // shipping discharge timer, counts whole ms while the bit is set
        if (opt_one[OPT1_SHIP_DCHG] && ms_tick) begin
            if (ship_ms == SHIP_MS - 8'h01) begin
                next_opt_one[OPT1_SHIP_DCHG] = 1'b0;
                next_ship_ms = 8'h00;
            end else begin
                next_ship_ms = ship_ms + 8'h01;
            end
        end

        // wakeup charge: capped run time, ends when battery recovers
        next_wake_charge = opt_one[OPT1_AUTO_WAKE] && sense.battery_below_min
                         && (wake_ms < WAKE_LIMIT_MS);
        if (!opt_one[OPT1_AUTO_WAKE]) begin
            next_wake_ms = 21'h000000;
        end else if (next_wake_charge && ms_tick) begin
            next_wake_ms = wake_ms + 21'h000001;
        end
        if (wake_charge_enable && !sense.battery_below_min) begin
            next_opt_one[OPT1_AUTO_WAKE] = 1'b0;
            next_wake_ms = 21'h000000;
        end

        // peak power phases, ms counted within each phase
        case (surge_state)
            SURGE_IDLE: begin
                if (trigger) begin
                    next_surge_state = SURGE_OVERLOAD;
                    next_surge_ms    = 6'h00;
                end
            end
            SURGE_OVERLOAD: begin
                if (ms_tick) begin
                    next_surge_ms = surge_ms + 6'h01;
                    if (surge_ms + 6'h01 >= ovld_len) begin
                        next_surge_ms = 6'h00;
                        // no room left in the cycle means no relax
                        next_surge_state = (ovld_len >= cycle_len) ? SURGE_IDLE
                                                                   : SURGE_RELAX;
                    end
                end
            end
            SURGE_RELAX: begin
                if (ms_tick) begin
                    next_surge_ms = surge_ms + 6'h01;
                    if (surge_ms + 6'h01 >= cycle_len - ovld_len) begin
                        next_surge_state = SURGE_IDLE;
                        next_surge_ms    = 6'h00;
                    end
                end
            end
            default: begin
                next_surge_state = SURGE_IDLE;
                next_surge_ms    = 6'h00;
            end
        endcase

        // host writes land after the timer clears so a software set beats them; adapter removal still clears the enables
        if (wr_one) begin
            next_opt_one = reg_req.wdata;
            if (reg_req.wdata[OPT1_SHIP_DCHG]) begin
                next_ship_ms = 8'h00;
            end
            if (!reg_req.wdata[OPT1_AUTO_WAKE]) begin
                next_wake_ms = 21'h000000;
            end
        end
        if (wr_two) begin
            next_opt_two = reg_req.wdata;
            if (!reg_req.wdata[OPT2_OVLD_FLAG] && surge_state == SURGE_OVERLOAD) begin
                next_surge_state = SURGE_IDLE;
                next_surge_ms    = 6'h00;
            end
            if (!reg_req.wdata[OPT2_RELAX_FLAG] && surge_state == SURGE_RELAX) begin
                next_surge_state = SURGE_IDLE;
                next_surge_ms    = 6'h00;
            end
        end

        // an absent adapter cannot feed a peak, so the enables drop
        if (!sense.adapter_present) begin
            next_opt_two[OPT2_ON_CURRENT] = 1'b0;
            next_opt_two[OPT2_ON_DROOP]   = 1'b0;
        end
        if (!next_opt_two[OPT2_ON_CURRENT] && !next_opt_two[OPT2_ON_DROOP]) begin
            next_surge_state = SURGE_IDLE;
            next_surge_ms    = 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // read path: phase flags replace the stored bits
    // ----------------------------------------------------------------
    always_comb begin
        opt_two_view = opt_two;
        opt_two_view[OPT2_OVLD_FLAG]  = (surge_state == SURGE_OVERLOAD);
        opt_two_view[OPT2_RELAX_FLAG] = (surge_state == SURGE_RELAX);
        if (reg_req.addr == ADDR_OPT_ONE) begin
            next_reg_rdata = opt_one;
        end else if (reg_req.addr == ADDR_OPT_TWO) begin
            next_reg_rdata = opt_two_view;
        end else begin
            next_reg_rdata = 16'h0000;    // unmapped codes read as zero
        end
        if (!reg_req.rd) begin
            next_reg_rdata = reg_rdata;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            tick_cnt              <= 14'h0000;
            opt_one               <= RESET_OPT_ONE;
            opt_two               <= RESET_OPT_TWO;
            ship_ms               <= 8'h00;
            wake_ms               <= 21'h000000;
            latched               <= 1'b0;
            surge_state           <= SURGE_IDLE;
            surge_ms              <= 6'h00;
            reg_rdata             <= 16'h0000;
            reg_rvalid            <= 1'b0;
            converter_disable     <= 1'b0;
            input_good_indicator  <= 1'b0;
            ship_discharge_active <= 1'b0;
            wake_charge_enable    <= 1'b0;
            surge_overload_active <= 1'b0;
            surge_relax_active    <= 1'b0;
        end else begin
            tick_cnt              <= next_tick_cnt;
            opt_one               <= next_opt_one;
            opt_two               <= next_opt_two;
            ship_ms               <= next_ship_ms;
            wake_ms               <= next_wake_ms;
            latched               <= next_latched;
            surge_state           <= next_surge_state;
            surge_ms              <= next_surge_ms;
            reg_rdata             <= next_reg_rdata;
            reg_rvalid            <= reg_req.rd;
            converter_disable     <= next_latched;
            input_good_indicator  <= sense.adapter_present && !next_latched;
            ship_discharge_active <= next_opt_one[OPT1_SHIP_DCHG];
            wake_charge_enable    <= next_wake_charge;
            surge_overload_active <= (next_surge_state == SURGE_OVERLOAD);
            surge_relax_active    <= (next_surge_state == SURGE_RELAX);
        end
    end

endmodule

`default_nettype wire

// ===== bench/ccpo_option_ctrl_props.sv
// checker for the option block port relations
`timescale 1ns/10ps
`default_nettype none
module ccpo_option_props
    import ccpo_pkg::*;
#(
    parameter int unsigned MS_TICK_CYCLES = 10
) (
    input wire logic          sys_clk,
    input wire logic          rst_n,
    input wire ccpo_reg_req_t reg_req,
    input wire logic [15:0]   reg_rdata,
    input wire logic          reg_rvalid,
    input wire ccpo_sense_t   sense_pins,
    input wire logic          converter_disable,
    input wire logic          input_good_indicator,
    input wire logic          ship_discharge_active,
    input wire logic          wake_charge_enable,
    input wire logic          surge_overload_active,
    input wire logic          surge_relax_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ------------------------
    // helper logic
    // ------------------------
    logic [2:0]  cfg;  // latch config mirrored from writes, not a port
    int unsigned ovl_cnt;
    int unsigned rlx_cnt;
    int unsigned ship_cnt;
    wire logic   cfg_ok = cfg[0] && (cfg[2:1] != 2'b00);
    wire logic   surge  = surge_overload_active || surge_relax_active;
    wire logic   wr_two = reg_req.wr && (reg_req.addr == ADDR_OPT_TWO);
    // phase and discharge lengths in cycles
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg      <= {RESET_OPT_ONE[5:4], RESET_OPT_ONE[3]};
            ovl_cnt  <= 0;
            rlx_cnt  <= 0;
            ship_cnt <= 0;
        end else begin
            if (reg_req.wr && (reg_req.addr == ADDR_OPT_ONE)) begin
                cfg <= {reg_req.wdata[5:4], reg_req.wdata[3]};
            end
            ovl_cnt  <= surge_overload_active ? ovl_cnt + 1 : 0;
            rlx_cnt  <= surge_relax_active ? rlx_cnt + 1 : 0;
            ship_cnt <= ship_discharge_active ? ship_cnt + 1 : 0;
        end
    end
    // ------------------------
    // assertions
    // ------------------------
    a_latch_gates_good: assert property (converter_disable |-> !input_good_indicator)
        else $error("input good high while latched off");
    a_latch_needs_cfg: assert property ($rose(converter_disable) |-> $past(cfg_ok))
        else $error("latch-off while comparator or latch disabled");
    a_adapter_gone_idle: assert property (!sense_pins.adapter_present [*8] |-> !surge)
        else $error("peak power active without adapter");
    a_phase_exclusive: assert property (!(surge_overload_active && surge_relax_active))
        else $error("overload and relax both active");
    a_overload_bound: assert property (ovl_cnt <= 21 * MS_TICK_CYCLES)
        else $error("overload phase too long");
    a_relax_bound: assert property (rlx_cnt <= 40 * MS_TICK_CYCLES)
        else $error("relax phase too long");
    a_relax_entry: assert property ($rose(surge_relax_active)
        |-> $past(surge_overload_active)) else $error("relax entered not from overload");
    a_ovld_write_exit: assert property (wr_two && !reg_req.wdata[11]
        && surge_overload_active |-> ##[1:2] !surge_overload_active)
        else $error("overload kept after clear");
    a_relax_write_exit: assert property (wr_two && !reg_req.wdata[10] && surge_relax_active
        |-> ##[1:2] !surge_relax_active) else $error("relax kept after clear");
    a_ship_bound: assert property (ship_cnt <= 141 * MS_TICK_CYCLES + 4)
        else $error("ship discharge not self-cleared");
    c_latch: cover property ($rose(converter_disable));
    c_relax: cover property ($fell(surge_relax_active));
    c_ship: cover property ($fell(ship_discharge_active));
endmodule
bind ccpo_option_ctrl ccpo_option_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) ccpo_option_props_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .sense_pins(sense_pins), .converter_disable(converter_disable),
    .input_good_indicator(input_good_indicator), .ship_discharge_active(ship_discharge_active),
    .wake_charge_enable(wake_charge_enable), .surge_overload_active(surge_overload_active),
    .surge_relax_active(surge_relax_active)
);
`default_nettype wire

// ===== bench/ccpo_host_model.sv
// host model issuing whole-word register requests to the option block
`timescale 1ns/10ps
`default_nettype none
module ccpo_host_model
    import ccpo_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic [15:0]   reg_rdata,
    input  wire logic          reg_rvalid,
    output var  ccpo_reg_req_t reg_req
);
    initial reg_req = '0;
    // one-edge request; idle address and data inverted to expose stale use
    task automatic send(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // answer taken from the valid pulse, unknown if none comes
    task automatic read_word(input logic [7:0] a, output logic [15:0] d);
        d = 'x;
        send(1'b0, a, 16'h0000);
        repeat (3) begin
            @(posedge sys_clk);
            if (reg_rvalid === 1'b1) d = reg_rdata;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_charger_peak_power_option_control.sv
// self-checking bench for the charger option control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin fail_count++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_charger_peak_power_option_control
    import ccpo_pkg::*;
;
    localparam int MS = 10;  // shortened ms tick keeps the run small
    logic          sys_clk;
    logic          rst_n;
    ccpo_sense_t   sense;
    ccpo_reg_req_t reg_req;
    logic [15:0]   reg_rdata;
    logic          reg_rvalid;
    logic          conv_off, good, ship, wake, ovl, rlx;
    logic [15:0]   rd_data;
    logic [15:0]   shadow [2] = '{16'h0211, 16'h02b7};  // model of words 0x30, 0x31
    logic [15:0]   lcfg [3] = '{16'h0219, 16'h0209, 16'h0211};
    int            ovt [4] = '{1, 2, 10, 20};
    int            cyt [4] = '{5, 10, 20, 40};
    int            fail_count = 0, tests_run = 0, n, m, r;
    // ------------------------
    // clock, design and host
    // ------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ccpo_option_ctrl #(.MS_TICK_CYCLES(MS)) ccpo_option_ctrl_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .sense_pins(sense), .converter_disable(conv_off),
        .input_good_indicator(good), .ship_discharge_active(ship), .wake_charge_enable(wake),
        .surge_overload_active(ovl), .surge_relax_active(rlx));
    ccpo_host_model ccpo_host_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_req(reg_req));
    // ------------------------
    // tasks
    // ------------------------
    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // flag bits are hardware-owned, so the model never stores them
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        ccpo_host_model_inst.send(1'b1, a, d);
        if (a == ADDR_OPT_ONE) shadow[0] = d;
        if (a == ADDR_OPT_TWO) shadow[1] = d & 16'hf3ff;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] flags);
        logic [15:0] ex;
        ex = (a == ADDR_OPT_ONE) ? shadow[0] : (a == ADDR_OPT_TWO) ? shadow[1] | flags : 16'h0;
        ccpo_host_model_inst.read_word(a, rd_data);
        `CHK("register read", ex, rd_data)
    endtask
    // hold one sense pin high long enough to pass the filter
    task automatic pulse(input int idx, input int len);
        @(posedge sys_clk);
        sense[idx] <= 1'b1;
        repeat (len) @(posedge sys_clk);
        sense[idx] <= 1'b0;
    endtask
    task automatic wait_ovl(input logic want);
        n = 0;
        while (ovl !== want && n < 60) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("overload phase", want, ovl)
        if (n == 60) stop_test();
    endtask
    // ------------------------
    // scenarios
    // ------------------------
    initial begin
        rst_n = 1'b0;
        sense = 5'b01000;
        void'($urandom(32'h1010417f));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd_chk(ADDR_OPT_ONE, 16'h0);
        rd_chk(ADDR_OPT_TWO, 16'h0);
        // random words; ship bit kept clear, unmapped codes ignored
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_OPT_ONE, 16'($urandom) & 16'hfffd);
            wr(ADDR_OPT_TWO, 16'($urandom));
            wr({1'b1, 7'($urandom)}, 16'($urandom));
            rd_chk({1'b1, 7'($urandom)}, 16'h0);
            rd_chk(ADDR_OPT_ONE, 16'h0);
            rd_chk(ADDR_OPT_TWO, 16'h0);
        end
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_OPT_ONE, lcfg[i]);
            pulse(4, 8);
            `CHK("power path off", i == 0, conv_off)
            `CHK("input good", i != 0, good)
            wr(ADDR_OPT_ONE, 16'h0211);
            repeat (4) @(posedge sys_clk);
            `CHK("power path off", 1'b0, conv_off)
        end
        wr(ADDR_OPT_ONE, 16'h0213);
        repeat (2) @(posedge sys_clk);
        n = 0;
        while (ship === 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("ship time", 1'b1, n >= 139 * MS - 4 && n <= 140 * MS + 2)
        if (n == 2000) stop_test();
        shadow[0] = 16'h0211;
        rd_chk(ADDR_OPT_ONE, 16'h0);
        sense.battery_below_min <= 1'b1;
        repeat (8) @(posedge sys_clk);
        `CHK("wake charge", 1'b1, wake)
        sense.battery_below_min <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK("wake charge", 1'b0, wake)
        shadow[0] = 16'h0210;
        rd_chk(ADDR_OPT_ONE, 16'h0);
        // trigger enables, then host exits from each phase
        wr(ADDR_OPT_TWO, 16'h02b7);
        pulse(1, 3);
        pulse(0, 3);
        repeat (10) @(posedge sys_clk);
        `CHK("surge phase", 2'b00, {ovl, rlx})
        wr(ADDR_OPT_TWO, 16'h12b7);
        pulse(1, 3);
        repeat (10) @(posedge sys_clk);
        `CHK("surge phase", 2'b00, {ovl, rlx})
        wr(ADDR_OPT_TWO, 16'hd3b7);
        pulse(0, 3);
        wait_ovl(1'b1);
        rd_chk(ADDR_OPT_TWO, 16'h0800);
        wr(ADDR_OPT_TWO, 16'hd3b7);
        repeat (3) @(posedge sys_clk);
        `CHK("overload phase", 1'b0, ovl)
        wr(ADDR_OPT_TWO, 16'h13b7);
        pulse(0, 3);
        wait_ovl(1'b1);
        wait_ovl(1'b0);
        rd_chk(ADDR_OPT_TWO, 16'h0400);
        wr(ADDR_OPT_TWO, 16'h13b7);
        repeat (3) @(posedge sys_clk);
        `CHK("relax phase", 1'b0, rlx)
        wr(ADDR_OPT_TWO, 16'hf2b7);
        pulse(0, 3);
        wait_ovl(1'b1);
        sense.adapter_present <= 1'b0;
        repeat (10) @(posedge sys_clk);
        `CHK("overload phase", 1'b0, ovl)
        sense.adapter_present <= 1'b1;
        repeat (8) @(posedge sys_clk);
        shadow[1] = 16'hc2b7;
        rd_chk(ADDR_OPT_TWO, 16'h0);
        // every overload and cycle selection, phase lengths measured
        for (int ov = 0; ov < 4; ov++) begin
            for (int cy = 0; cy < 4; cy++) begin
                wr(ADDR_OPT_TWO, {ov[1:0], 4'b1000, cy[1:0], 8'hb7});
                pulse(1, 3);
                wait_ovl(1'b1);
                n = 0;
                m = 0;
                r = (cyt[cy] > ovt[ov]) ? (cyt[cy] - ovt[ov]) * MS : 0;
                while (ovl === 1'b1 && n < 300) begin
                    @(posedge sys_clk);
                    n++;
                end
                while (rlx === 1'b1 && m < 500) begin
                    @(posedge sys_clk);
                    m++;
                end
                `CHK("overload time", 1'b1, n >= (ovt[ov]-1)*MS-1 && n <= ovt[ov]*MS+2)
                `CHK("relax time", 1'b1, (r == 0) ? m == 0 : m >= r-MS-1 && m <= r+2)
                if (n == 300 || m == 500) stop_test();
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
